// ===== uaf_pkg.sv
// shared constants and types of the uart alternate-function block
// assumes a 32-bit apb slave on a single 200 mhz clock
package uaf_pkg;
	localparam int PERIOD_W = 21;
	localparam logic [PERIOD_W-1:0] PERIOD_ONE = 21'h000001;
	// register byte offsets
	localparam logic [11:0] ADDR_BAUD = 12'h024;
	localparam logic [11:0] ADDR_IRDA = 12'h030;
	localparam logic [11:0] ADDR_ALT = 12'h034;
	localparam logic [11:0] ADDR_FUN = 12'h038;
	localparam logic [11:0] ADDR_COMP = 12'h03c;
	localparam logic [11:0] ADDR_ISTAT = 12'h040;
	localparam logic [11:0] ADDR_IMASK = 12'h044;
	localparam logic [11:0] ADDR_FRAME = 12'h048;
	// values after reset and writable bits
	localparam logic [31:0] RST_IRDA = 32'h00000040;
	localparam logic [31:0] RST_ZERO = 32'h00000000;
	localparam logic [31:0] WMASK_BAUD = 32'h8000ffff;
	localparam logic [31:0] WMASK_IRDA = 32'h00000062;
	localparam logic [31:0] WMASK_ALT = 32'hff0f01f7;
	localparam logic [31:0] WMASK_COMP = 32'h800001ff;
	// field positions
	localparam int BAUD_DIV16 = 31;
	localparam int IR_RX_INVERT = 6;
	localparam int IR_TX_INVERT = 5;
	localparam int IR_TX_SEL = 1;
	localparam int ALT_STATION_LSB = 24;
	localparam int ALT_ADDR_EN = 19;
	localparam int ALT_AUTO_DIR = 18;
	localparam int ALT_AUTO_ADDR = 17;
	localparam int ALT_MULTIDROP = 16;
	localparam int ALT_BIT_ERR = 8;
	localparam int ALT_LIN_TX = 7;
	localparam int ALT_LIN_RX = 6;
	localparam int ALT_HSEL_LSB = 4;
	localparam int COMP_DEC = 31;
	// interrupt status bits
	localparam int INT_TXHDR = 0;
	localparam int INT_RXHDR = 1;
	localparam int INT_BITERR = 2;
	localparam int INT_ADDR = 3;
	localparam int INT_W = 4;
	// frame and lin constants
	localparam logic [4:0] LIN_BREAK_BASE = 5'h08;
	localparam logic [7:0] LIN_SYNC_BYTE = 8'h55;
	localparam logic [4:0] FRAME_LEN = 5'h0a;
	localparam logic [4:0] FRAME_LEN_PAR = 5'h0b;
	localparam logic [3:0] RX_LAST = 4'h8;
	localparam logic [3:0] RX_LAST_PAR = 4'h9;
	localparam logic [9:0] RX_MASK = 10'h1ff;
	localparam logic [9:0] RX_MASK_PAR = 10'h3ff;
	typedef enum logic [1:0] {FUN_UART = 2'h0, FUN_LIN = 2'h1, FUN_IRDA = 2'h2, FUN_RS485 = 2'h3} uaf_fun_e;
	typedef enum logic [1:0] {HSEL_BRK = 2'h0, HSEL_SYNC = 2'h1, HSEL_PID = 2'h2, HSEL_RSVD = 2'h3} uaf_hsel_e;
	typedef enum logic [2:0] {TX_IDLE = 3'h0, TX_BREAK = 3'h1, TX_SYNC = 3'h3, TX_PID = 3'h2, TX_DATA = 3'h6} uaf_tx_e;
	typedef enum logic [1:0] {RX_IDLE = 2'h0, RX_START = 2'h1, RX_BITS = 2'h3} uaf_rx_e;
endpackage

// ===== uaf_bit_if.sv
// bit-timer control bundle between the channel logic and a bit timer
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface uaf_bit_if;
	import uaf_pkg::*;
	logic load;
	logic half;
	logic comp_en;
	logic comp_dec;
	logic [PERIOD_W-1:0] period;
	logic tick;
	modport ctl(output load, output half, output comp_en, output comp_dec, output period, input tick);
	modport tmr(input load, input half, input comp_en, input comp_dec, input period, output tick);
endinterface

// ===== uaf_bit_timer.sv
// one bit-period down counter with per-bit compensation
// assumes the controller reloads it in the tick cycle to chain bits
`timescale 1ns/1ps
module uaf_bit_timer
	import uaf_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// control bundle
	uaf_bit_if.tmr bt
);
	typedef struct packed {
		logic run;
		logic [PERIOD_W-1:0] cnt;
	} uaf_tmr_s;
	uaf_tmr_s q;
	uaf_tmr_s n;
	logic [PERIOD_W-1:0] len;
	always_comb begin
		len = bt.period;
		if (bt.half) begin
			len = bt.period >> 1;
		end else if (bt.comp_en && bt.comp_dec) begin
			len = bt.period - PERIOD_ONE;
		end else if (bt.comp_en) begin
			len = bt.period + PERIOD_ONE;
		end
		if (len == '0) begin
			len = PERIOD_ONE;
		end
		n = q;
		if (bt.load) begin
			n.run = 1'b1;
			n.cnt = len - PERIOD_ONE;
		end else if (q.run) begin
			if (q.cnt == '0) begin
				n.run = 1'b0;
			end else begin
				n.cnt = q.cnt - PERIOD_ONE;
			end
		end
	end
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end
	assign bt.tick = q.run && (q.cnt == '0);
endmodule

// ===== uaf_top.sv
// uart alternate-function channel: lin, irda, rs-485 and bit compensation
// assumes an apb master on ref_clk_in and a transceiver on the serial pins
// Notes on behaviour
// - receive-invert bit flips the serial input before sampling.
// - transmit-invert bit flips the serial output.
// - in infrared mode direction bit picks receiver (0) or transmitter (1).
// - function field picks uart, lin, infrared or rs-485.
// - rs-485 station address is the top byte of alternate control.
// - lin identifier parity bits are generated from the six id bits.
// - address-detect enable turns on hardware address matching in rs-485.
// - in rs-485 mode auto-direction drives the line driver enable while transmitting.
// - lin bit error raises an interrupt when readback differs.
// - header trigger starts a header, clears itself, raises an interrupt.
// - lin receive raises an interrupt after the selected header part.
// - header select: break, break+sync, break+sync+identifier; 11 reserved.
// - transmitted break lasts the break count plus eight bit times.
// - nine-bit pattern marks compensated data bits and parity bit.
// - marked bits lengthen by one clock, or shorten when direction set.
// - bit period is divisor plus one, times sixteen in divide mode.
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
module uaf_top
	import uaf_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// apb slave
	input wire logic [11:0] paddr_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// serial line
	input wire logic rx_pin_in,
	output logic tx_pin_out,
	output logic line_dir_out,
	// byte streams
	input wire logic [7:0] tx_data_in,
	input wire logic tx_valid_in,
	output logic tx_ready_out,
	output logic [7:0] rx_data_out,
	output logic rx_valid_out,
	output logic rx_addr_out,
	// interrupt
	output logic irq_out
);
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [31:0] baud;
		logic [31:0] irda;
		logic [31:0] alt;
		logic [31:0] comp;
		logic [1:0] fun;
		logic [INT_W-1:0] istat;
		logic [INT_W-1:0] imask;
		logic par_en;
		logic rx_s1;
		logic rx_s2;
		logic rx_prev;
		uaf_tx_e tx_st;
		logic [15:0] tx_sh;
		logic [4:0] tx_left;
		logic [3:0] tx_pos;
		uaf_rx_e rx_st;
		logic [9:0] rx_sh;
		logic [3:0] rx_cnt;
		logic [1:0] lin_stage;
		logic aad_hit;
		logic [7:0] rx_data;
		logic rx_valid;
		logic rx_addr;
		logic tx_line;
		logic dir;
		logic tx_ready;
		logic irq;
	} uaf_state_s;

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] uaf_frame(input logic [7:0] b, input logic par);
		logic [15:0] f;
		f = {6'h00, 1'b1, b, 1'b0};
		if (par) begin
			f = {5'h00, 1'b1, ^b, b, 1'b0};
		end
		return f;
	endfunction

	function automatic logic [7:0] uaf_pid(input logic [5:0] id);
		logic p0;
		logic p1;
		p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
		p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
		return {p1, p0, id};
	endfunction

	// pos counts from the start bit: 1..8 are data bits, 9 the parity bit
	function automatic logic uaf_comp_hit(input logic [8:0] pat, input logic [3:0] pos, input logic par);
		logic hit;
		hit = 1'b0;
		if (pos >= 4'h1 && pos <= 4'h8) begin
			hit = pat[pos - 4'h1];
		end else if (pos == 4'h9 && par) begin
			hit = pat[8];
		end
		return hit;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	uaf_state_s q;
	uaf_state_s n;
	uaf_fun_e fun;
	uaf_hsel_e hsel;
	logic [16:0] brd_inc;
	logic [PERIOD_W-1:0] period;
	logic [INT_W-1:0] ev;
	logic rx_bit;
	logic acc;
	logic done;
	logic wr;
	logic rd_clr;
	logic mapped;
	logic [31:0] rd;
	logic t_load;
	logic t_comp;
	logic r_load;
	logic r_half;
	logic r_comp;
	logic take;
	logic hdr_go;
	logic hdr_done;
	logic tx_allowed;
	logic bf;
	logic [15:0] bf_sh;
	logic [4:0] bf_len;
	uaf_tx_e bf_st;
	logic [4:0] brk_len;
	logic [9:0] w;
	logic [3:0] rx_last;
	logic frame_done;
	logic brk;
	logic deliver;
	logic is_addr;
	logic [7:0] data;

	uaf_bit_if tx_tm();
	uaf_bit_if rx_tm();

	uaf_bit_timer u_tx_timer (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.bt(tx_tm.tmr)
	);

	uaf_bit_timer u_rx_timer (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.bt(rx_tm.tmr)
	);

	assign tx_tm.load = t_load;
	assign tx_tm.half = 1'b0;
	assign tx_tm.comp_en = t_comp;
	assign tx_tm.comp_dec = q.comp[COMP_DEC];
	assign tx_tm.period = period;
	assign rx_tm.load = r_load;
	assign rx_tm.half = r_half;
	assign rx_tm.comp_en = r_comp;
	assign rx_tm.comp_dec = q.comp[COMP_DEC];
	assign rx_tm.period = period;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		n = q;
		ev = '0;
		fun = uaf_fun_e'(q.fun);
		hsel = uaf_hsel_e'(q.alt[ALT_HSEL_LSB +: 2]);
		brd_inc = {1'b0, q.baud[15:0]} + 17'h00001;
		period = {4'h0, brd_inc};
		if (q.baud[BAUD_DIV16]) begin
			period = {brd_inc, 4'h0};
		end
		// pin synchroniser; only the second stage is looked at
		n.rx_s1 = rx_pin_in;
		n.rx_s2 = q.rx_s1;
		// receiver is deaf while the infrared path is set to transmit
		rx_bit = (q.rx_s2 ^ q.irda[IR_RX_INVERT]) | (fun == FUN_IRDA && q.irda[IR_TX_SEL]);
		n.rx_prev = rx_bit;

		// transmit engine
		t_load = 1'b0;
		t_comp = 1'b0;
		hdr_done = 1'b0;
		bf = 1'b0;
		bf_sh = '0;
		bf_len = '0;
		bf_st = TX_IDLE;
		tx_allowed = !(fun == FUN_IRDA && !q.irda[IR_TX_SEL]);
		take = tx_valid_in & q.tx_ready;
		hdr_go = (fun == FUN_LIN) & q.alt[ALT_LIN_TX];
		brk_len = {2'h0, q.alt[2:0]} + LIN_BREAK_BASE;
		case (q.tx_st)
			TX_IDLE: begin
				if (take) begin
					bf = 1'b1;
					bf_sh = uaf_frame(tx_data_in, q.par_en);
					bf_len = q.par_en ? FRAME_LEN_PAR : FRAME_LEN;
					bf_st = TX_DATA;
				end else if (hdr_go) begin
					// low for the break, then one high delimiter bit
					bf = 1'b1;
					bf_sh = 16'h0001 << brk_len;
					bf_len = brk_len + 5'h01;
					bf_st = TX_BREAK;
				end
			end
			default: begin
				if (tx_tm.tick) begin
					if (q.tx_left != 5'h01) begin
						n.tx_sh = q.tx_sh >> 1;
						n.tx_left = q.tx_left - 5'h01;
						n.tx_pos = q.tx_pos + 4'h1;
						t_load = 1'b1;
						t_comp = (q.tx_st == TX_DATA) && uaf_comp_hit(q.comp[8:0], q.tx_pos + 4'h1, q.par_en);
					end else begin
						case (q.tx_st)
							TX_BREAK: begin
								if (hsel == HSEL_SYNC || hsel == HSEL_PID) begin
									bf = 1'b1;
									bf_sh = uaf_frame(LIN_SYNC_BYTE, 1'b0);
									bf_len = FRAME_LEN;
									bf_st = TX_SYNC;
								end else begin
									hdr_done = 1'b1;
								end
							end
							TX_SYNC: begin
								if (hsel == HSEL_PID) begin
									bf = 1'b1;
									bf_sh = uaf_frame(uaf_pid(q.alt[ALT_STATION_LSB +: 6]), 1'b0);
									bf_len = FRAME_LEN;
									bf_st = TX_PID;
								end else begin
									hdr_done = 1'b1;
								end
							end
							TX_PID: begin
								hdr_done = 1'b1;
							end
							default: begin
								n.tx_st = TX_IDLE;
							end
						endcase
					end
				end
			end
		endcase
		if (hdr_done) begin
			n.tx_st = TX_IDLE;
			n.alt[ALT_LIN_TX] = 1'b0;
			ev[INT_TXHDR] = 1'b1;
		end
		if (bf) begin
			n.tx_sh = bf_sh;
			n.tx_left = bf_len;
			n.tx_pos = 4'h0;
			n.tx_st = bf_st;
			t_load = 1'b1;
		end
		// readback lags by the synchroniser, well inside one bit
		if (fun == FUN_LIN && q.alt[ALT_BIT_ERR] && tx_tm.tick && q.tx_st != TX_IDLE && rx_bit != q.tx_sh[0]) begin
			ev[INT_BITERR] = 1'b1;
		end
		n.tx_line = ((n.tx_st == TX_IDLE) ? 1'b1 : n.tx_sh[0]) ^ q.irda[IR_TX_INVERT];
		n.dir = 1'b0;
		if (fun == FUN_RS485 && q.alt[ALT_AUTO_DIR]) begin
			n.dir = (n.tx_st != TX_IDLE);
		end else if (fun == FUN_IRDA) begin
			n.dir = q.irda[IR_TX_SEL];
		end

		// receive engine
		r_load = 1'b0;
		r_half = 1'b0;
		r_comp = 1'b0;
		frame_done = 1'b0;
		rx_last = q.par_en ? RX_LAST_PAR : RX_LAST;
		w = q.rx_sh;
		w[q.rx_cnt] = rx_bit;
		case (q.rx_st)
			RX_IDLE: begin
				if (q.rx_prev && !rx_bit) begin
					r_load = 1'b1;
					r_half = 1'b1;
					n.rx_st = RX_START;
				end
			end
			RX_START: begin
				if (rx_tm.tick) begin
					if (!rx_bit) begin
						r_load = 1'b1;
						r_comp = uaf_comp_hit(q.comp[8:0], 4'h1, q.par_en);
						n.rx_cnt = 4'h0;
						n.rx_st = RX_BITS;
					end else begin
						n.rx_st = RX_IDLE;
					end
				end
			end
			RX_BITS: begin
				if (rx_tm.tick) begin
					n.rx_sh = w;
					if (q.rx_cnt != rx_last) begin
						n.rx_cnt = q.rx_cnt + 4'h1;
						r_load = 1'b1;
						r_comp = uaf_comp_hit(q.comp[8:0], q.rx_cnt + 4'h2, q.par_en);
					end else begin
						frame_done = 1'b1;
						n.rx_st = RX_IDLE;
					end
				end
			end
			default: begin
				n.rx_st = RX_IDLE;
			end
		endcase
		data = w[7:0];
		brk = ~|(w & (q.par_en ? RX_MASK_PAR : RX_MASK));
		is_addr = (fun == FUN_RS485) && q.par_en && w[8];
		deliver = 1'b1;
		if (frame_done && fun == FUN_LIN && q.alt[ALT_LIN_RX]) begin
			if (brk) begin
				deliver = 1'b0;
				n.lin_stage = 2'h1;
				ev[INT_RXHDR] = (hsel == HSEL_BRK || hsel == HSEL_RSVD);
			end else if (q.lin_stage == 2'h1) begin
				n.lin_stage = (data == LIN_SYNC_BYTE) ? 2'h2 : 2'h0;
				ev[INT_RXHDR] = (data == LIN_SYNC_BYTE) && (hsel == HSEL_SYNC);
			end else if (q.lin_stage == 2'h2) begin
				n.lin_stage = 2'h0;
				ev[INT_RXHDR] = (hsel == HSEL_PID);
			end
		end
		if (frame_done && fun == FUN_RS485 && q.alt[ALT_ADDR_EN]) begin
			// auto-address wins if software breaks the exclusion
			if (is_addr) begin
				ev[INT_ADDR] = (data == q.alt[ALT_STATION_LSB +: 8]);
				if (q.alt[ALT_AUTO_ADDR]) begin
					n.aad_hit = ev[INT_ADDR];
					deliver = ev[INT_ADDR];
				end
			end else if (q.alt[ALT_AUTO_ADDR]) begin
				deliver = q.aad_hit;
			end
		end
		n.rx_valid = frame_done & deliver;
		if (frame_done) begin
			n.rx_data = data;
			n.rx_addr = is_addr;
		end

		// apb slave: one wait state, writes land on the completing edge
		acc = psel_in & penable_in;
		done = acc & q.pready;
		n.pready = acc & ~q.pready;
		mapped = 1'b1;
		rd = '0;
		case (paddr_in)
			ADDR_BAUD: rd = q.baud;
			ADDR_IRDA: rd = q.irda;
			ADDR_ALT: rd = q.alt;
			ADDR_FUN: rd = {30'h00000000, q.fun};
			ADDR_COMP: rd = q.comp;
			ADDR_ISTAT: rd = {28'h0000000, q.istat};
			ADDR_IMASK: rd = {28'h0000000, q.imask};
			ADDR_FRAME: rd = {31'h00000000, q.par_en};
			default: mapped = 1'b0;
		endcase
		n.prdata = '0;
		n.pslverr = 1'b0;
		if (acc && !q.pready) begin
			n.prdata = pwrite_in ? 32'h00000000 : rd;
			n.pslverr = ~mapped;
		end
		wr = done & pwrite_in & mapped;
		rd_clr = done & ~pwrite_in & (paddr_in == ADDR_ISTAT);
		if (wr) begin
			case (paddr_in)
				ADDR_BAUD: n.baud = pwdata_in & WMASK_BAUD;
				ADDR_IRDA: n.irda = pwdata_in & WMASK_IRDA;
				ADDR_ALT: n.alt = pwdata_in & WMASK_ALT;
				ADDR_FUN: n.fun = pwdata_in[1:0];
				ADDR_COMP: n.comp = pwdata_in & WMASK_COMP;
				ADDR_IMASK: n.imask = pwdata_in[INT_W-1:0];
				ADDR_FRAME: n.par_en = pwdata_in[0];
				default: ;
			endcase
		end
		// an event in the clearing cycle survives the read
		n.istat = (q.istat & ~{INT_W{rd_clr}}) | ev;
		n.irq = |(n.istat & n.imask);
		n.tx_ready = (n.tx_st == TX_IDLE) && !bf && tx_allowed && !(fun == FUN_LIN && n.alt[ALT_LIN_TX]);
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			q <= '0;
			q.baud <= RST_ZERO;
			q.irda <= RST_IRDA;
			q.alt <= RST_ZERO;
			q.comp <= RST_ZERO;
			q.rx_s1 <= 1'b1;
			q.rx_s2 <= 1'b1;
			// receive inversion is on after reset, so the idle line reads low
			q.rx_prev <= ~RST_IRDA[IR_RX_INVERT];
			q.tx_line <= 1'b1;
		end else begin
			q <= n;
		end
	end

	assign prdata_out = q.prdata;
	assign pready_out = q.pready;
	assign pslverr_out = q.pslverr;
	assign tx_pin_out = q.tx_line;
	assign line_dir_out = q.dir;
	assign tx_ready_out = q.tx_ready;
	assign rx_data_out = q.rx_data;
	assign rx_valid_out = q.rx_valid;
	assign rx_addr_out = q.rx_addr;
	assign irq_out = q.irq;
endmodule

// ===== uaf_props.sv
// port checker for the alternate-function channel
// assumes it is bound into uaf_top and sees only its ports
`timescale 1ns/1ps
module uaf_props
	import uaf_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// apb slave
	input wire logic [11:0] paddr_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	// serial and streams
	input wire logic tx_pin_out,
	input wire logic line_dir_out,
	input wire logic tx_ready_out,
	input wire logic rx_valid_out,
	input wire logic rx_addr_out,
	input wire logic irq_out
);
	logic [1:0] fun_q;
	logic [3:0] mask_q;
	logic dir_q, inv_q, aud_q, wr_ok, mapped;
	assign wr_ok = psel_in && penable_in && pwrite_in && pready_out;
	assign mapped = paddr_in inside {ADDR_BAUD, ADDR_IRDA, ADDR_ALT, ADDR_FUN, ADDR_COMP, ADDR_ISTAT, ADDR_IMASK,
		ADDR_FRAME};
	// shadow of the few control bits whose effect shows at the pins
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fun_q <= 2'h0;
			mask_q <= 4'h0;
			{dir_q, inv_q, aud_q} <= 3'h0;
		end else if (wr_ok) begin
			if (paddr_in == ADDR_FUN) fun_q <= pwdata_in[1:0];
			if (paddr_in == ADDR_IMASK) mask_q <= pwdata_in[3:0];
			if (paddr_in == ADDR_IRDA) {inv_q, dir_q} <= {pwdata_in[IR_TX_INVERT], pwdata_in[IR_TX_SEL]};
			if (paddr_in == ADDR_ALT) aud_q <= pwdata_in[ALT_AUTO_DIR];
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	ready_timing_a: assert property (psel_in && penable_in && !pready_out |=> pready_out) else $error("pready late");
	ready_pulse_a: assert property (pready_out |=> !pready_out) else $error("pready longer than one cycle");
	rdata_idle_a: assert property (!pready_out |-> prdata_out == 32'h0) else $error("read data outside access");
	slverr_map_a: assert property (pready_out |-> pslverr_out == !mapped) else $error("slave error mismatch");
	dir_irda_a: assert property (fun_q == FUN_IRDA && $stable(fun_q) && $stable(dir_q) |-> line_dir_out == dir_q)
		else $error("infrared direction wrong");
	irda_refuse_a: assert property (fun_q == FUN_IRDA && !dir_q && $stable(fun_q) && $stable(dir_q) |-> !tx_ready_out)
		else $error("transmit accepted in receive direction");
	dir_plain_a: assert property (fun_q inside {FUN_UART, FUN_LIN} && $stable(fun_q) |-> !line_dir_out)
		else $error("driver enabled outside rs-485 and infrared");
	tx_idle_a: assert property (tx_ready_out && $stable(inv_q) |-> tx_pin_out == !inv_q)
		else $error("idle level ignores transmit inversion");
	auto_dir_a: assert property (fun_q == FUN_RS485 && aud_q && $fell(tx_ready_out) |-> ##[0:2] line_dir_out)
		else $error("auto direction did not enable driver");
	irq_mask_a: assert property (irq_out |-> mask_q != 4'h0) else $error("interrupt while all masked");
	rx_pulse_a: assert property (rx_valid_out |=> !rx_valid_out) else $error("rx valid longer than one cycle");
	addr_flag_a: assert property (rx_valid_out && rx_addr_out |-> fun_q == FUN_RS485)
		else $error("address flag outside rs-485");
	cover property (fun_q == FUN_LIN && $fell(irq_out));
	cover property (rx_valid_out && rx_addr_out);
	cover property (pslverr_out);
endmodule
bind uaf_top uaf_props u_props(.ref_clk_in, .rst_n_in, .paddr_in, .psel_in, .penable_in, .pwrite_in, .pwdata_in,
	.prdata_out, .pready_out, .pslverr_out, .tx_pin_out, .line_dir_out, .tx_ready_out, .rx_valid_out, .rx_addr_out,
	.irq_out);

// ===== uaf_node.sv
// behavioural serial node on the far side of the transceiver
// assumes the line idles high through a pull-up when nobody drives it
`timescale 1ns/1ps
module uaf_node (
	// clock
	input wire logic clk_in,
	// serial line
	input wire logic tx_line_in,
	output logic rx_line_out
);
	int per = 4;
	int mode = 0;
	logic drv = 1'b1;
	logic [7:0] b;
	logic [7:0] got[$];
	// mode 1 echoes the line back, mode 2 holds it low to force readback errors
	assign rx_line_out = (mode == 1) ? tx_line_in : (mode == 2) ? 1'b0 : drv;
	task automatic send(input logic [8:0] d, input int nb, input logic inv);
		@(posedge clk_in);
		for (int i = 0; i < nb + 2; i++) begin
			drv <= ((i == 0) ? 1'b0 : (i > nb) ? 1'b1 : d[i-1]) ^ inv;
			repeat (per) @(posedge clk_in);
		end
	endtask
	// mid-bit sampling tolerates one clock of compensation either way
	initial forever begin
		@(negedge tx_line_in);
		repeat (per / 2) @(posedge clk_in);
		for (int i = 0; i < 8; i++) begin
			repeat (per) @(posedge clk_in);
			b[i] = tx_line_in;
		end
		repeat (per) @(posedge clk_in);
		wait (tx_line_in === 1'b1);
		got.push_back(b);
	end
endmodule

// ===== tb_top.sv
// self-checking bench of the alternate-function channel
// assumes uaf_node as the far-side partner on the serial pins
`timescale 1ns/1ps
module tb_top;
	import uaf_pkg::*;
	logic ref_clk_in, rst_n_in, psel, penable, pwrite, err, tx_valid;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, rx_pin, tx_pin, line_dir, tx_ready, rx_valid, rx_addr, irq;
	logic [7:0] tx_data, rx_data;
	logic [7:0] hexp[3];
	logic [31:0] bauds[3] = '{32'h3, 32'h3, 32'h80000000};
	logic [31:0] comps[3] = '{32'h1, 32'h80000001, 32'h0};
	int slen[3] = '{4, 4, 16};
	int hlen[3] = '{5, 3, 16};
	int error_cnt = 0, tests_run = 0, cyc = 0, rx_cnt = 0, n, i;
	uaf_top u_dut(.ref_clk_in, .rst_n_in, .paddr_in(paddr), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .rx_pin_in(rx_pin),
		.tx_pin_out(tx_pin), .line_dir_out(line_dir), .tx_data_in(tx_data), .tx_valid_in(tx_valid),
		.tx_ready_out(tx_ready), .rx_data_out(rx_data), .rx_valid_out(rx_valid), .rx_addr_out(rx_addr), .irq_out(irq));
	uaf_node u_node(.clk_in(ref_clk_in), .tx_line_in(tx_pin), .rx_line_out(rx_pin));
	initial begin
		ref_clk_in = 1'b0;
		forever #2.5 ref_clk_in = ~ref_clk_in;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic conclude;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk_in);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk_in);
		penable <= 1'b1;
		do @(posedge ref_clk_in); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string s);
		apb(1'b0, a, 32'h0);
		chk(s, e, rd);
	endtask
	task automatic send(input logic [7:0] d);
		@(posedge ref_clk_in);
		tx_data <= d;
		tx_valid <= 1'b1;
		do @(posedge ref_clk_in); while (tx_ready !== 1'b1);
		tx_valid <= 1'b0;
	endtask
	task automatic runlen(input logic v, output int len);
		len = 0;
		while (tx_pin !== v) @(posedge ref_clk_in);
		while (tx_pin === v) begin
			@(posedge ref_clk_in);
			len++;
		end
	endtask
	task automatic rxget(input logic [7:0] d, input logic a);
		int k;
		k = 0;
		do begin
			@(posedge ref_clk_in);
			k++;
		end while (rx_valid !== 1'b1 && k < 400);
		chk("rx byte and flag", {23'h0, a, d}, {23'h0, rx_addr, rx_data});
	endtask
	task automatic wait_hdr;
		int k;
		k = 0;
		do begin
			apb(1'b0, ADDR_ALT, 32'h0);
			k++;
		end while (rd[ALT_LIN_TX] !== 1'b0 && k < 100);
		chk("header trigger", 32'h0, {31'h0, rd[ALT_LIN_TX]});
	endtask
	function automatic logic [7:0] pid_of(input logic [5:0] id);
		return {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
	endfunction
	always @(posedge ref_clk_in) begin
		cyc++;
		if (rx_valid === 1'b1) rx_cnt++;
		if (cyc == 30000) begin
			error_cnt++;
			conclude();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{rst_n_in, psel, penable, pwrite, tx_valid, paddr, pwdata, tx_data} = '0;
		hexp = '{8'h00, 8'h55, pid_of(6'h2a)};
		repeat (3) @(posedge ref_clk_in);
		rst_n_in <= 1'b1;
		rdc(ADDR_ALT, RST_ZERO, "alternate reset");
		rdc(ADDR_FUN, RST_ZERO, "function reset");
		rdc(ADDR_COMP, RST_ZERO, "compensation reset");
		rdc(ADDR_IRDA, RST_IRDA, "infrared reset");
		rdc(12'h100, RST_ZERO, "unmapped read");
		chk("unmapped error", 32'h1, {31'h0, err});
		wr(ADDR_ALT, 32'hff0d017f);
		rdc(ADDR_ALT, 32'hff0d0177, "alternate fields");
		wr(ADDR_ALT, 32'h0);
		wr(ADDR_COMP, 32'hffffffff);
		rdc(ADDR_COMP, WMASK_COMP, "compensation fields");
		for (i = 0; i < 4; i++) begin
			wr(ADDR_FUN, i);
			rdc(ADDR_FUN, i, "function select");
		end
		wr(ADDR_FUN, FUN_IRDA);
		wr(ADDR_IRDA, 32'h0);
		repeat (3) @(posedge ref_clk_in);
		chk("receive direction", 32'h0, {30'h0, line_dir, tx_ready});
		wr(ADDR_IRDA, 32'h2);
		repeat (3) @(posedge ref_clk_in);
		chk("transmit direction", 32'h3, {30'h0, line_dir, tx_ready});
		wr(ADDR_FUN, FUN_UART);
		wr(ADDR_IRDA, 32'h20);
		repeat (3) @(posedge ref_clk_in);
		chk("inverted idle", 32'h0, {31'h0, tx_pin});
		wr(ADDR_IRDA, 32'h0);
		repeat (200) @(posedge ref_clk_in);
		for (i = 0; i < 3; i++) begin
			wr(ADDR_BAUD, bauds[i]);
			wr(ADDR_COMP, comps[i]);
			u_node.per = slen[i];
			u_node.got.delete();
			send(8'h01);
			runlen(1'b0, n);
			chk("start bit length", slen[i], n);
			runlen(1'b1, n);
			chk("first data bit length", hlen[i], n);
			repeat (12 * slen[i]) @(posedge ref_clk_in);
			chk("byte on line", 32'h1, u_node.got[0]);
		end
		wr(ADDR_BAUD, 32'h3);
		u_node.per = 4;
		wr(ADDR_FUN, FUN_LIN);
		wr(ADDR_IMASK, 32'hf);
		u_node.mode = 1;
		for (i = 0; i < 3; i++) begin
			u_node.got.delete();
			// receive stays on so the own header is read back
			// ten bit times at least, so the receiver sees an all-zero frame
			wr(ADDR_ALT, {8'h2a, 16'h0, 2'b11, i[1:0], 1'b0, 3'(i + 2)});
			runlen(1'b0, n);
			chk("break length", (i + 10) * 4, n);
			wait_hdr();
			repeat (20) @(posedge ref_clk_in);
			chk("header irq", 32'h1, {31'h0, irq});
			rdc(ADDR_ISTAT, 32'h3, "header status");
			repeat (3) @(posedge ref_clk_in);
			chk("irq after read", 32'h0, {31'h0, irq});
			chk("header bytes", i + 1, u_node.got.size());
			chk("header last byte", hexp[i], u_node.got[i]);
		end
		wr(ADDR_IMASK, 32'h0);
		u_node.mode = 2;
		wr(ADDR_ALT, 32'h190);
		wait_hdr();
		chk("masked irq", 32'h0, {31'h0, irq});
		rdc(ADDR_ISTAT, 32'h5, "bit error status");
		u_node.mode = 0;
		wr(ADDR_ALT, 32'h0);
		wr(ADDR_FUN, FUN_RS485);
		wr(ADDR_FRAME, 32'h1);
		wr(ADDR_IMASK, 32'h8);
		wr(ADDR_ALT, 32'h5a0d0000);
		fork
			u_node.send(9'h15a, 9, 1'b0);
			rxget(8'h5a, 1'b1);
		join
		chk("address irq", 32'h1, {31'h0, irq});
		rdc(ADDR_ISTAT, 32'h8, "address status");
		fork
			u_node.send(9'h011, 9, 1'b0);
			rxget(8'h11, 1'b0);
		join
		send(8'h3c);
		repeat (3) @(posedge ref_clk_in);
		chk("driver during frame", 32'h1, {31'h0, line_dir});
		repeat (60) @(posedge ref_clk_in);
		chk("driver after frame", 32'h0, {31'h0, line_dir});
		wr(ADDR_ALT, 32'h5a0e0000);
		n = rx_cnt;
		u_node.send(9'h133, 9, 1'b0);
		u_node.send(9'h044, 9, 1'b0);
		repeat (10) @(posedge ref_clk_in);
		chk("filtered bytes", n, rx_cnt);
		fork
			u_node.send(9'h15a, 9, 1'b0);
			rxget(8'h5a, 1'b1);
		join
		fork
			u_node.send(9'h077, 9, 1'b0);
			rxget(8'h77, 1'b0);
		join
		wr(ADDR_FUN, FUN_UART);
		wr(ADDR_FRAME, 32'h0);
		wr(ADDR_ALT, 32'h0);
		fork
			u_node.send(9'h03c, 8, 1'b0);
			rxget(8'h3c, 1'b0);
		join
		wr(ADDR_IRDA, 32'h40);
		u_node.drv <= 1'b0;
		// the switch may look like a start bit, so let any false frame finish
		repeat (60) @(posedge ref_clk_in);
		fork
			u_node.send(9'h0c3, 8, 1'b1);
			rxget(8'hc3, 1'b0);
		join
		conclude();
	end
endmodule
